// ==== logic/msci_top.sv ====
// Contract
// RULE1 - Output-enable command resumes forwarding radio data and answers accepted.
// RULE2 - After re-enable, buffered packets go out first, then new ones.
// RULE3 - Forwarding of received data is enabled after reset.
// RULE4 - Multidrop mode: act only on commands suffixed with own station address.
// RULE5 - Accepted commands get acknowledge, rejected get error; no error reply in multidrop.
// RULE6 - Headerless mode relay command sets two addresses or reports both.
// RULE7 - Relay set by command is temporary; default comes from slot 13.
// RULE8 - Relay command is not allowed in multidrop mode.
// RULE9 - Packet mode: reception-disable stops accepting radio packets, answers accepted.
// RULE10 - Packet mode: reception-enable resumes accepting radio packets, answers accepted.
// RULE11 - Reset loads reception enable from bit 7 of slot 22.
// RULE12 - Slot command addresses 00-27; value is two hex digits plus H.
// RULE13 - Slot command without value returns the slot contents.
// RULE14 - Failed slot write answers the store-failure code.
// RULE15 - Slot writes take effect only after reset or restart command.
// RULE16 - Terminal reinitialises the store after a write failure.
// RULE17 - Identity query returns twelve digits: three zeros, nine serial digits.
// RULE18 - Reported identity comes from the most recently received packet.
// RULE19 - Identity is all zeros before any packet is received.
// RULE20 - Sender identity is independent of identification slots 04 and 05.
// RULE21 - Terminal may embed its own serial identity in payloads.
// RULE22 - While output is disabled, received data stays in the receive buffer.
// RULE23 - Commands are at-sign, three letters, parameters, CR/LF; replies end CR/LF.
// RULE24 - Forwarded packet is RXT tag, three-digit sender, payload, CR/LF.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "msci_regs.svh"
module msci_top #(
	parameter int LINE_MAX = 24,
	parameter int RXQ_DEPTH = 64
) (
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic CMD_VALID_I,
	input wire logic [7:0] CMD_DATA_I,
	output logic CMD_READY_O,
	output logic TX_VALID_O,
	output logic [7:0] TX_DATA_O,
	input wire logic TX_READY_I,
	input wire msci_pkg::msci_radio_type RADIO_I,
	output logic RADIO_READY_O,
	input wire logic MULTIDROP_I,
	input wire logic HEADERLESS_I,
	input wire logic PACKET_MODE_I,
	input wire logic [23:0] LOCAL_ADDR_I,
	output logic [4:0] STORE_ADDR_O,
	output logic STORE_WE_O,
	output logic [7:0] STORE_WDATA_O,
	input wire logic [7:0] STORE_RDATA_I,
	input wire logic STORE_FAIL_I,
	output logic OUT_EN_O,
	output logic RADIO_RX_EN_O,
	output logic [47:0] RELAY_ADDR_O
);
	import msci_pkg::*;

	localparam int QAW = $clog2(RXQ_DEPTH);

	if (LINE_MAX < 12 || LINE_MAX > 31) begin : g_chk_line
		$error("LINE_MAX must lie in 12..31");
	end
	if (RXQ_DEPTH < 2 || (1 << QAW) != RXQ_DEPTH) begin : g_chk_q
		$error("RXQ_DEPTH must be a power of two");
	end

	function automatic logic is_dec(input logic [7:0] c);
		return c >= "0" && c <= "9";
	endfunction

	function automatic logic [4:0] hex_nib(input logic [7:0] c);
		if (is_dec(c)) begin
			return {1'b1, c[3:0]};
		end else if (c >= "A" && c <= "F") begin
			return {1'b1, 4'(c[3:0] + 4'h9)};
		end
		return 5'h00;
	endfunction

	function automatic logic [7:0] hex_chr(input logic [3:0] n);
		return (n < 4'ha) ? {4'h3, n} : 8'(8'h37 + {4'h0, n});
	endfunction

	msci_state_type state;
	msci_kind_type kind;
	logic [7:0] line [0:LINE_MAX-1];
	logic [4:0] len;
	logic ovf;
	logic [95:0] resp_w;
	logic [3:0] resp_len;
	logic [3:0] resp_idx;
	logic restart;
	logic [71:0] last_serial;
	logic [4:0] el;
	logic md_ok;
	logic [23:0] cmd;
	logic [7:0] slot_num;
	logic [4:0] nib_hi;
	logic [4:0] nib_lo;
	logic resp_busy;
	logic resp_end;

	msci_rxq_type rxq [0:RXQ_DEPTH-1];
	logic [QAW:0] wr_ptr;
	logic [QAW:0] rd_ptr;
	logic q_full;
	logic q_empty;
	logic push;
	logic keep;
	logic keep_q;
	logic pop;

	msci_rxq_type fwd_ent;
	logic fwd_act;
	logic [3:0] fwd_ph;
	logic line_open;
	logic tx_load;
	logic take_fwd;
	logic take_resp;
	logic [7:0] fwd_ch;

	assign CMD_READY_O = (state == S_COLLECT);
	assign resp_busy = (state == S_RESP);
	assign cmd = {line[1], line[2], line[3]};
	assign slot_num = 8'((line[4] - 8'h30) * 8'd10 + (line[5] - 8'h30));
	assign nib_hi = hex_nib(line[7]);
	assign nib_lo = hex_nib(line[8]);

	always_comb begin
		el = len;
		md_ok = 1'b1;
		if (MULTIDROP_I) begin
			md_ok = (len >= 5'd7) && ({line[len-3], line[len-2], line[len-1]} == LOCAL_ADDR_I); // RULE4
			el = 5'(len - 5'd3);
			if (md_ok && line[el-1] == ";") begin
				el = 5'(el - 5'd1);
			end
		end
		kind = K_NAK;
		if (!md_ok) begin
			kind = K_IGN; // RULE4
		end else if (line[0] == "@" && el >= 5'd4 && !ovf) begin // RULE23
			case (cmd)
				`MSCI_CMD_OUT_ON: kind = (el == 5'd4) ? K_OUT_ON : K_NAK;
				`MSCI_CMD_OUT_OFF: kind = (el == 5'd4) ? K_OUT_OFF : K_NAK;
				`MSCI_CMD_RX_OFF: kind = (el == 5'd4 && PACKET_MODE_I) ? K_RXOFF : K_NAK; // RULE9
				"REN": kind = (el == 5'd4 && PACKET_MODE_I) ? K_RXON : K_NAK; // RULE10
				`MSCI_CMD_SND_ID: kind = (el == 5'd4) ? K_SND_ID : K_NAK;
				"RST": kind = (el == 5'd4) ? K_RST : K_NAK;
				`MSCI_CMD_RELAY: begin
					if (!MULTIDROP_I && HEADERLESS_I) begin // RULE8
						if (el == 5'd4) begin
							kind = K_PASRD; // RULE6
						end else if (el == 5'd12 && line[4] == ":" && line[8] == ":") begin
							kind = K_PASWR; // RULE6
						end
					end
				end
				"REG": begin
					if (el >= 5'd6 && is_dec(line[4]) && is_dec(line[5])
							&& slot_num <= `MSCI_SLOT_MAX) begin // RULE12
						if (el == 5'd6) begin
							kind = K_REGRD; // RULE13
						end else if (el == 5'd10 && line[6] == ":" && nib_hi[4] && nib_lo[4]
								&& line[9] == "H") begin
							kind = K_REGWR; // RULE12
						end
					end
				end
				default: kind = K_NAK;
			endcase
		end
		if (kind == K_NAK && MULTIDROP_I) begin
			kind = K_IGN; // RULE5
		end
	end

	// Command collection, decode and replies
	always_ff @(posedge CLK_I) begin
		STORE_WE_O <= 1'b0;
		if (!RST_B_I) begin
			state <= S_BOOT_A;
			len <= 5'h00;
			ovf <= 1'b0;
			resp_w <= 96'h0;
			resp_len <= 4'h0;
			restart <= 1'b0;
			OUT_EN_O <= 1'b1; // RULE3
			RADIO_RX_EN_O <= 1'b0;
			RELAY_ADDR_O <= {`MSCI_ZERO3, `MSCI_ZERO3};
			STORE_ADDR_O <= `MSCI_SLOT_RELAY;
			STORE_WDATA_O <= 8'h00;
		end else begin
			case (state)
				S_BOOT_A: begin
					RELAY_ADDR_O <= {8'h30, hex_chr(STORE_RDATA_I[7:4]),
						hex_chr(STORE_RDATA_I[3:0]), `MSCI_ZERO3}; // RULE7
					STORE_ADDR_O <= `MSCI_SLOT_BOOT;
					state <= S_BOOT_B;
				end
				S_BOOT_B: begin
					RADIO_RX_EN_O <= STORE_RDATA_I[`MSCI_BOOT_RXEN_BIT]; // RULE11
					state <= S_COLLECT;
				end
				S_COLLECT: begin
					if (CMD_VALID_I) begin
						if (CMD_DATA_I == `MSCI_LF) begin
							state <= S_DECODE; // RULE23
						end else if (CMD_DATA_I != `MSCI_CR) begin
							if (len < 5'(LINE_MAX)) begin
								line[len] <= CMD_DATA_I;
								len <= 5'(len + 5'd1);
							end else begin
								ovf <= 1'b1;
							end
						end
					end
				end
				S_DECODE: begin
					len <= 5'h00;
					ovf <= 1'b0;
					state <= S_RESP;
					resp_w <= {`MSCI_ACK, 80'h0}; // RULE5
					resp_len <= 4'h2;
					case (kind)
						K_IGN: state <= S_COLLECT;
						K_NAK: resp_w <= {`MSCI_NAK, 80'h0}; // RULE5
						K_OUT_ON: OUT_EN_O <= 1'b1; // RULE1
						K_OUT_OFF: OUT_EN_O <= 1'b0;
						K_RXOFF: RADIO_RX_EN_O <= 1'b0; // RULE9
						K_RXON: RADIO_RX_EN_O <= 1'b1; // RULE10
						K_SND_ID: begin
							resp_w <= {`MSCI_ZERO3, last_serial}; // RULE17
							resp_len <= 4'hc;
						end
						K_RST: restart <= 1'b1;
						K_PASRD: begin
							resp_w <= {RELAY_ADDR_O[47:24], ":", RELAY_ADDR_O[23:0], 40'h0}; // RULE6
							resp_len <= 4'h7;
						end
						K_PASWR: begin
							RELAY_ADDR_O <= {line[5], line[6], line[7], line[9], line[10], line[11]}; // RULE7
						end
						K_REGRD: begin
							STORE_ADDR_O <= slot_num[4:0];
							state <= S_RDWAIT;
						end
						K_REGWR: begin
							STORE_ADDR_O <= slot_num[4:0];
							STORE_WDATA_O <= {nib_hi[3:0], nib_lo[3:0]};
							STORE_WE_O <= 1'b1; // RULE15
							state <= S_WRWAIT;
						end
						default: state <= S_COLLECT;
					endcase
				end
				S_RDWAIT: begin
					resp_w <= {hex_chr(STORE_RDATA_I[7:4]), hex_chr(STORE_RDATA_I[3:0]), "H", 72'h0}; // RULE13
					resp_len <= 4'h3;
					state <= S_RESP;
				end
				S_WRWAIT: begin
					resp_w <= STORE_FAIL_I ? {`MSCI_NAK_STORE, 80'h0} : {`MSCI_ACK, 80'h0}; // RULE14
					resp_len <= 4'h2;
					state <= S_RESP;
				end
				S_RESP: begin
					if (resp_end) begin
						state <= restart ? S_BOOT_A : S_COLLECT;
						if (restart) begin
							// Restart reloads stored settings; temporary values are dropped
							restart <= 1'b0;
							OUT_EN_O <= 1'b1; // RULE15
							STORE_ADDR_O <= `MSCI_SLOT_RELAY;
						end
					end
				end
				default: state <= S_COLLECT;
			endcase
		end
	end

	// Sender identity of the newest accepted packet only
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			last_serial <= `MSCI_ZERO9; // RULE19
		end else if (push && RADIO_I.first) begin
			last_serial <= RADIO_I.serial; // RULE18 RULE20
		end
	end

	// Receive buffer
	assign q_full = (wr_ptr == {~rd_ptr[QAW], rd_ptr[QAW-1:0]});
	assign q_empty = (wr_ptr == rd_ptr);
	assign RADIO_READY_O = !q_full;
	assign keep = RADIO_I.first ? RADIO_RX_EN_O : keep_q; // RULE9 RULE10
	assign push = RADIO_I.valid && !q_full && keep; // RULE22

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			keep_q <= 1'b0;
		end else if (RADIO_I.valid && !q_full) begin
			keep_q <= keep;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			wr_ptr <= '0;
		end else if (push) begin
			rxq[wr_ptr[QAW-1:0]] <= '{RADIO_I.first, RADIO_I.last, RADIO_I.sender, RADIO_I.data};
			wr_ptr <= (QAW+1)'(wr_ptr + 1'b1);
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			rd_ptr <= '0;
		end else if (pop) begin
			rd_ptr <= (QAW+1)'(rd_ptr + 1'b1); // RULE2
		end
	end

	// A started line runs to its end so replies never split a packet
	assign pop = !fwd_act && !q_empty && (line_open || (OUT_EN_O && !resp_busy)); // RULE1 RULE22

	always_comb begin
		case (fwd_ph)
			4'h0: fwd_ch = "R"; // RULE24
			4'h1: fwd_ch = "X";
			4'h2: fwd_ch = "T";
			4'h3: fwd_ch = fwd_ent.sender[23:16];
			4'h4: fwd_ch = fwd_ent.sender[15:8];
			4'h5: fwd_ch = fwd_ent.sender[7:0];
			4'h6: fwd_ch = fwd_ent.data;
			4'h7: fwd_ch = `MSCI_CR;
			default: fwd_ch = `MSCI_LF;
		endcase
	end

	assign tx_load = !TX_VALID_O || TX_READY_I;
	assign take_fwd = tx_load && fwd_act;
	assign take_resp = tx_load && !fwd_act && !line_open && resp_busy;
	assign resp_end = take_resp && resp_idx == 4'(resp_len + 4'h1);

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			fwd_act <= 1'b0;
			fwd_ph <= 4'h0;
			line_open <= 1'b0;
			fwd_ent <= '0;
		end else if (pop) begin
			fwd_ent <= rxq[rd_ptr[QAW-1:0]];
			fwd_act <= 1'b1;
			fwd_ph <= rxq[rd_ptr[QAW-1:0]].first ? `MSCI_HDR_PH : `MSCI_DATA_PH; // RULE24
			line_open <= 1'b1;
		end else if (take_fwd) begin
			fwd_ph <= 4'(fwd_ph + 4'h1);
			if ((fwd_ph == `MSCI_DATA_PH && !fwd_ent.last) || fwd_ph == `MSCI_LF_PH) begin
				fwd_act <= 1'b0;
			end
			if (fwd_ph == `MSCI_LF_PH) begin
				line_open <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			resp_idx <= 4'h0;
		end else if (resp_end) begin
			resp_idx <= 4'h0;
		end else if (take_resp) begin
			resp_idx <= 4'(resp_idx + 4'h1);
		end
	end

	// Serial output stage
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			TX_VALID_O <= 1'b0;
			TX_DATA_O <= 8'h00;
		end else if (tx_load) begin
			TX_VALID_O <= take_fwd || take_resp;
			if (take_fwd) begin
				TX_DATA_O <= fwd_ch;
			end else if (take_resp) begin
				if (resp_idx < resp_len) begin
					TX_DATA_O <= resp_w[7'(7'd88 - {resp_idx, 3'b000}) +: 8];
				end else begin
					TX_DATA_O <= (resp_idx == resp_len) ? `MSCI_CR : `MSCI_LF; // RULE23
				end
			end
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);

	property p_oen;
		state == S_DECODE && kind == K_OUT_ON |=> OUT_EN_O && state == S_RESP
			&& resp_w[95:80] == `MSCI_ACK;
	endproperty
	a_oen: assert property (p_oen) else $error("enable command not honoured"); // RULE1

	sequence s_idle_ready;
		!fwd_act && !line_open && !resp_busy && OUT_EN_O && !q_empty;
	endsequence
	sequence s_line_start;
		fwd_act && fwd_ph == `MSCI_HDR_PH;
	endsequence
	property p_drain;
		s_idle_ready |=> s_line_start;
	endproperty
	a_drain: assert property (p_drain) else $error("buffered packet not started"); // RULE2

	property p_reset_out;
		$rose(RST_B_I) |-> OUT_EN_O && state == S_BOOT_A;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("output not enabled after reset"); // RULE3

	property p_md_ign;
		state == S_DECODE && MULTIDROP_I && !md_ok |=> state == S_COLLECT && $stable(OUT_EN_O);
	endproperty
	a_md_ign: assert property (p_md_ign) else $error("foreign address acted upon"); // RULE4

	property p_nak_quiet;
		state == S_RESP && MULTIDROP_I |-> resp_w[95:80] != `MSCI_NAK;
	endproperty
	a_nak_quiet: assert property (p_nak_quiet) else $error("error reply in multidrop mode"); // RULE5

	property p_rxoff;
		state == S_DECODE && kind == K_RXOFF |=> !RADIO_RX_EN_O ##1 !RADIO_I.first || !push;
	endproperty
	a_rxoff: assert property (p_rxoff) else $error("reception not disabled"); // RULE9

	property p_rxon;
		state == S_DECODE && kind == K_RXON |=> RADIO_RX_EN_O;
	endproperty
	a_rxon: assert property (p_rxon) else $error("reception not enabled"); // RULE10

	property p_boot;
		state == S_BOOT_B |=> RADIO_RX_EN_O == $past(STORE_RDATA_I[7]) && state == S_COLLECT;
	endproperty
	a_boot: assert property (p_boot) else $error("boot reception state wrong"); // RULE11

	property p_wfail;
		state == S_WRWAIT && STORE_FAIL_I |=> state == S_RESP && resp_w[95:80] == `MSCI_NAK_STORE;
	endproperty
	a_wfail: assert property (p_wfail) else $error("write failure not reported"); // RULE14

	property p_wr_defer;
		STORE_WE_O |-> ##1 $stable(RELAY_ADDR_O) [*2];
	endproperty
	a_wr_defer: assert property (p_wr_defer) else $error("slot write acted at once"); // RULE15

	property p_rid;
		state == S_DECODE && kind == K_SND_ID |=> resp_len == 4'hc && resp_w[95:72] == `MSCI_ZERO3;
	endproperty
	a_rid: assert property (p_rid) else $error("identity reply malformed"); // RULE17
endmodule // msci_top
`default_nettype wire

// ==== logic/msci_regs.svh ====
`ifndef MSCI_REGS_SVH
`define MSCI_REGS_SVH
`define MSCI_SLOT_RELAY 5'h0d
`define MSCI_SLOT_BOOT 5'h16
`define MSCI_SLOT_MAX 8'h1b
`define MSCI_BOOT_RXEN_BIT 7
`define MSCI_CR 8'h0d
`define MSCI_LF 8'h0a
`define MSCI_ZERO3 24'h30_3030
`define MSCI_ZERO9 72'h30_3030_3030_3030_3030
`define MSCI_HDR_PH 4'h0
`define MSCI_DATA_PH 4'h6
`define MSCI_LF_PH 4'h8
`define MSCI_CMD_OUT_ON 24'h4f_454e
`define MSCI_CMD_OUT_OFF 24'h4f_4441
`define MSCI_CMD_RX_OFF 24'h52_4441
`define MSCI_CMD_SND_ID 24'h52_4944
`define MSCI_CMD_RELAY 24'h50_4153
`define MSCI_ACK 16'h5030
`define MSCI_NAK 16'h4e30
`define MSCI_NAK_STORE 16'h4e36
`endif

// ==== logic/msci_pkg.sv ====
`default_nettype none
package msci_pkg;
	typedef enum logic [2:0] {
		S_BOOT_A = 3'b000,
		S_BOOT_B = 3'b001,
		S_COLLECT = 3'b010,
		S_DECODE = 3'b011,
		S_RDWAIT = 3'b100,
		S_WRWAIT = 3'b101,
		S_RESP = 3'b110
	} msci_state_type;
	typedef enum logic [3:0] {
		K_IGN = 4'b0000,
		K_NAK = 4'b0001,
		K_OUT_ON = 4'b0010,
		K_OUT_OFF = 4'b0011,
		K_RXOFF = 4'b0100,
		K_RXON = 4'b0101,
		K_SND_ID = 4'b0110,
		K_RST = 4'b0111,
		K_PASRD = 4'b1000,
		K_PASWR = 4'b1001,
		K_REGRD = 4'b1010,
		K_REGWR = 4'b1011
	} msci_kind_type;
	typedef struct packed {
		logic valid;
		logic first;
		logic last;
		logic [7:0] data;
		logic [23:0] sender;
		logic [71:0] serial;
	} msci_radio_type;
	typedef struct packed {
		logic first;
		logic last;
		logic [23:0] sender;
		logic [7:0] data;
	} msci_rxq_type;
endpackage
`default_nettype wire

// ==== testbench/msci_far.sv ====
`timescale 1ns/1ps
`default_nettype none
module msci_far (
	input wire logic clk_i,
	input wire logic [4:0] store_addr_i,
	input wire logic store_we_i,
	input wire logic [7:0] store_wdata_i,
	input wire logic fail_i,
	output logic [7:0] store_rdata_o,
	output logic store_fail_o,
	output logic tx_ready_o
);
	logic [7:0] mem [0:31];
	initial begin
		foreach (mem[i]) begin
			mem[i] = 8'h00;
		end
		mem[4] = 8'h39;
		mem[5] = 8'h38;
		mem[13] = 8'h4a;
		mem[22] = 8'h80;
	end
	assign store_rdata_o = mem[store_addr_i];
	// Failure shows beside the write pulse, where the block samples it
	assign store_fail_o = store_we_i && fail_i;
	// Random stalls, as a slow terminal would give
	always @(posedge clk_i) begin
		tx_ready_o <= ($urandom_range(0, 3) != 0);
		if (store_we_i && !fail_i) begin
			mem[store_addr_i] <= store_wdata_i;
		end
	end
endmodule // msci_far
`default_nettype wire

// ==== testbench/tb_modem_serial_command_set.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "msci_regs.svh"
module tb_modem_serial_command_set;
	import msci_pkg::*;
	logic clk, rst_b, cmd_valid, cmd_ready, tx_valid, tx_ready, radio_ready;
	logic multidrop, headerless, packet_mode, store_we, store_fail, fail_req, out_en, rx_en;
	logic [7:0] cmd_data, tx_data, store_wdata, store_rdata;
	logic [4:0] store_addr;
	logic [23:0] local_addr, snd_a, snd_b;
	logic [47:0] relay;
	logic [71:0] ser_a, ser_b;
	logic [31:0] pay_a, pay_b;
	logic [127:0] l;
	msci_radio_type radio;
	logic [7:0] rxq [$];
	int fails, checks_done;
	localparam logic [127:0] ack_accepted = {`MSCI_ACK, "\r\n"};
	localparam logic [127:0] nak_error = {`MSCI_NAK, "\r\n"};

	msci_top dut_u (.CLK_I(clk), .RST_B_I(rst_b), .CMD_VALID_I(cmd_valid), .CMD_DATA_I(cmd_data),
		.CMD_READY_O(cmd_ready), .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data),
		.TX_READY_I(tx_ready), .RADIO_I(radio), .RADIO_READY_O(radio_ready),
		.MULTIDROP_I(multidrop), .HEADERLESS_I(headerless), .PACKET_MODE_I(packet_mode),
		.LOCAL_ADDR_I(local_addr), .STORE_ADDR_O(store_addr), .STORE_WE_O(store_we),
		.STORE_WDATA_O(store_wdata), .STORE_RDATA_I(store_rdata), .STORE_FAIL_I(store_fail),
		.OUT_EN_O(out_en), .RADIO_RX_EN_O(rx_en), .RELAY_ADDR_O(relay));
	msci_far far_u (.clk_i(clk), .store_addr_i(store_addr), .store_we_i(store_we),
		.store_wdata_i(store_wdata), .fail_i(fail_req), .store_rdata_o(store_rdata),
		.store_fail_o(store_fail), .tx_ready_o(tx_ready));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			rxq.push_back(tx_data);
		end
	end

	task automatic check(string name, logic [127:0] seen, logic [127:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic send(string s);
		@(posedge clk);
		for (int i = 0; i < s.len(); i++) begin
			cmd_valid <= 1'b1;
			cmd_data <= s[i];
			@(negedge clk);
			while (cmd_ready !== 1'b1) @(negedge clk);
			@(posedge clk);
		end
		cmd_valid <= 1'b0;
	endtask
	// Bounded so a missing line terminator cannot hang the run
	task automatic get_line(output logic [127:0] v);
		logic [7:0] b;
		int n;
		v = '0;
		b = '0;
		n = 0;
		while (b !== 8'h0a && n < 2000) begin
			@(negedge clk);
			n++;
			if (rxq.size() > 0) begin
				b = rxq.pop_front();
				v = {v[119:0], b};
			end
		end
	endtask
	task automatic cmd(string s, logic [127:0] exp);
		send({s, "\r\n"});
		get_line(l);
		check(s, l, exp);
	endtask
	task automatic quiet(string name);
		repeat (60) @(posedge clk);
		check(name, 128'(rxq.size()), 128'h0);
	endtask
	task automatic pkt(logic [23:0] snd, logic [71:0] ser, logic [31:0] pay);
		@(posedge clk);
		for (int i = 0; i < 4; i++) begin
			radio <= {1'b1, i == 0, i == 3, pay[31 - 8 * i -: 8], snd, ser};
			@(negedge clk);
			while (radio_ready !== 1'b1) @(negedge clk);
			@(posedge clk);
		end
		radio <= {1'b0, ~radio[$bits(radio) - 2:0]};
	endtask
	function automatic logic [71:0] rnd_ser();
		for (int i = 0; i < 9; i++) begin
			rnd_ser[8 * i +: 8] = 8'h30 + 8'($urandom_range(0, 9));
		end
	endfunction
	function automatic logic [31:0] rnd_pay();
		for (int i = 0; i < 4; i++) begin
			rnd_pay[8 * i +: 8] = 8'h41 + 8'($urandom_range(0, 25));
		end
	endfunction
	function automatic logic [127:0] exp_rx(logic [23:0] snd, logic [31:0] pay);
		return {"RXT", snd, pay, "\r\n"};
	endfunction
	// Command line built from the coded command letters
	function automatic string op(logic [23:0] c, string tail);
		return $sformatf("@%s%s", c, tail);
	endfunction

	initial begin
		#(40ns * 20000);
		fails++;
		$display("watchdog expired");
		stop_test();
	end

	initial begin
		{rst_b, cmd_valid, multidrop, headerless, fail_req, cmd_data} = '0;
		radio = '0;
		packet_mode = 1'b1;
		local_addr = "A22";
		void'($urandom(32'h9c76));
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		check("out_en", 128'(out_en), 128'h1);
		check("rx_en", 128'(rx_en), 128'h1);
		check("relay", 128'(relay), 128'("04A000"));
		cmd(op(`MSCI_CMD_SND_ID, ""), {"000000000000", "\r\n"});
		$display("test reset done");
		snd_a = {16'h3030, 8'h30 + 8'($urandom_range(0, 9))};
		snd_b = {16'h3030, 8'h30 + 8'($urandom_range(0, 9))};
		ser_a = rnd_ser();
		ser_b = rnd_ser();
		pay_a = rnd_pay();
		// Sending terminal carries part of its own serial in the payload
		pay_b = ser_b[31:0];
		cmd(op(`MSCI_CMD_OUT_OFF, ""), ack_accepted);
		pkt(snd_a, ser_a, pay_a);
		pkt(snd_b, ser_b, pay_b);
		quiet("held");
		cmd(op(`MSCI_CMD_OUT_ON, ""), ack_accepted);
		get_line(l);
		check("first", l, exp_rx(snd_a, pay_a));
		get_line(l);
		check("second", l, exp_rx(snd_b, pay_b));
		cmd(op(`MSCI_CMD_SND_ID, ""), {"000", ser_b, "\r\n"});
		check("embedded_id", l[47:16], pay_b);
		$display("test output done");
		cmd(op(`MSCI_CMD_RX_OFF, ""), ack_accepted);
		check("rx_off", 128'(rx_en), 128'h0);
		pkt(snd_a, ser_a, pay_a);
		quiet("dropped");
		cmd("@REN", ack_accepted);
		check("rx_on", 128'(rx_en), 128'h1);
		@(posedge clk);
		packet_mode <= 1'b0;
		cmd(op(`MSCI_CMD_RX_OFF, ""), nak_error);
		@(posedge clk);
		packet_mode <= 1'b1;
		$display("test reception done");
		cmd($sformatf("@REG%02d", `MSCI_SLOT_RELAY), "4AH\r\n");
		cmd("@REG05:5AH", ack_accepted);
		check("slot5", 128'(far_u.mem[5]), 128'h5a);
		cmd("@REG28", nak_error);
		@(posedge clk);
		fail_req <= 1'b1;
		cmd("@REG06:11H", {`MSCI_NAK_STORE, "\r\n"});
		@(posedge clk);
		fail_req <= 1'b0;
		cmd("@REG06:11H", ack_accepted);
		check("slot6", 128'(far_u.mem[6]), 128'h11);
		$display("test slots done");
		cmd(op(`MSCI_CMD_RELAY, ""), nak_error);
		@(posedge clk);
		headerless <= 1'b1;
		cmd(op(`MSCI_CMD_RELAY, ":002:A00"), ack_accepted);
		check("relay_set", 128'(relay), 128'("002A00"));
		cmd(op(`MSCI_CMD_RELAY, ""), "002:A00\r\n");
		cmd($sformatf("@REG%02d:31H", `MSCI_SLOT_RELAY), ack_accepted);
		check("relay_kept", 128'(relay), 128'("002A00"));
		cmd("@RST", ack_accepted);
		repeat (4) @(posedge clk);
		check("relay_new", 128'(relay), 128'("031000"));
		$display("test relay done");
		@(posedge clk);
		multidrop <= 1'b1;
		cmd(op(`MSCI_CMD_OUT_ON, "A22"), ack_accepted);
		cmd($sformatf("@REG%02d;A22", `MSCI_SLOT_RELAY), "31H\r\n");
		send(op(`MSCI_CMD_OUT_OFF, "001\r\n"));
		quiet("other_station");
		check("out_kept", 128'(out_en), 128'h1);
		send(op(`MSCI_CMD_RELAY, "A22\r\n"));
		quiet("no_nak");
		$display("test multidrop done");
		stop_test();
	end
endmodule // tb_modem_serial_command_set
`default_nettype wire
